// ==== verilog/eba_regs.svh ====
// Constants for the external bus arbitration and cycle shaping block.
// Assumes inclusion by the package and the design modules; definitions only.
// Notes on behaviour
// - In multiplexed mode the latch strobe lasts 0.5 or 1.5 cycles, one select bit.
// - After reset the strobe width is the longer 1.5 cycles; here every access takes its width from latch_strobe_width_sel_i.
// - The chosen strobe width applies to every access, whatever the block.
// - With recovery on, one or two dummy cycles separate back-to-back cycles.
// - Read and write recovery are selected independently, per block.
// - Each block has its own dummy count; the completed access's block decides.
// - The outside master gets only the external bus, never internal resources.
// - Internal RAM, ROM and register accesses continue while the bus is granted.
// - External requests stall while granted away; no pre-emption of the master.
// - The request is sampled at the end of each external bus cycle.
// - Grant asserts acknowledge and floats address, data and control together.
// - Acknowledge asserts only once the current bus cycle has completed.
// - A dynamically sized transfer finishes all its cycles before a grant.
// - A pending request is accepted only at an external bus cycle boundary.
// - A request during a two-cycle recovery waits until a waiting access's bus cycle completes.
// - On request release the device drops acknowledge and retakes the bus.
`ifndef EBA_REGS_SVH
`define EBA_REGS_SVH
`define EBA_BLOCKS        4
`define EBA_BLK_W         2
`define EBA_RCV_W         2
`define EBA_ADDR_PHASE    2
`define EBA_DATA_PHASE    1
`define EBA_WAIT_W        3
`define EBA_ALE_RST       1'b1
`define EBA_RCV_OFF       2'h0
`define EBA_RCV_ONE       2'h1
`define EBA_RCV_TWO       2'h2
`endif

// ==== verilog/eba_pkg.sv ====
// Types shared by the external bus arbitration block.
// Assumes the constants header is on the include path.
`include "eba_regs.svh"
package eba_pkg;
	typedef enum logic [2:0] {
		EBA_IDLE,
		EBA_ADDR,
		EBA_STRB,
		EBA_DATA,
		EBA_RCV,
		EBA_GRANT
	} eba_state_t;
endpackage

// ==== verilog/eba_sync.sv ====
// Two-stage synchroniser for an asynchronous level.
// Assumes the input comes from a pin outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module eba_sync (
	input  wire logic clock_i,  // System clock.
	input  wire logic srst_i,   // Synchronous reset, active high.
	input  wire logic rst_val_i,// Level held during reset.
	input  wire logic async_i,  // Asynchronous level.
	output logic      sync_o    // Synchronised level.
);
	logic meta_q;
	logic meta_d;
	logic sync_d;

	always_comb begin
		meta_d = srst_i ? rst_val_i : async_i;
		sync_d = srst_i ? rst_val_i : meta_q;
	end

	always_ff @(posedge clock_i) begin
		meta_q <= meta_d;
		sync_o <= sync_d;
	end
endmodule
`default_nettype wire

// ==== verilog/eba_arbiter.sv ====
// External bus cycle shaping (strobe width, recovery) and bus grant logic.
// Assumes one requester presents one external cycle at a time with block, direction
// and a flag saying more pieces of a sized transfer follow; internal accesses bypass.
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.svh"
module eba_arbiter
	import eba_pkg::*;
(
	input  wire logic                   clock_i,                // 125 MHz system clock.
	input  wire logic                   srst_i,                 // Synchronous reset.
	input  wire logic                   mux_mode_i,             // 1: multiplexed bus mode.
	input  wire logic                   latch_strobe_width_sel_i, // 1: 1.5 cycles.
	input  wire logic [2*`EBA_BLOCKS-1:0] read_recovery_sel_i,  // Per block, 2 bits.
	input  wire logic [2*`EBA_BLOCKS-1:0] write_recovery_sel_i, // Per block, 2 bits.
	input  wire logic                   ext_req_i,              // External access request.
	input  wire logic [`EBA_BLK_W-1:0]  ext_blk_i,              // Target address block.
	input  wire logic                   ext_write_i,            // 1: write access.
	input  wire logic                   ext_more_i,             // More sized pieces follow.
	input  wire logic                   int_req_i,              // Internal memory access.
	input  wire logic                   ext_master_request_n_i, // Outside master request.
	output logic                        ext_ack_o,              // External access done.
	output logic                        int_ack_o,              // Internal access done.
	output logic                        ext_stall_o,            // External request stalled.
	output logic                        latch_strobe_o,         // Address latch strobe.
	output logic                        latch_strobe_half_o,    // Half-cycle extension.
	output logic                        rd_strobe_o,            // Read strobe, active high.
	output logic                        wr_strobe_o,            // Write strobe, active high.
	output logic                        bus_oe_o,               // Address/data/control drive.
	output logic                        dummy_cycle_o,          // Recovery cycle in progress.
	output logic                        ext_master_grant_n_o    // Acknowledge, active low.
);
	eba_state_t                 state_q, state_d;
	logic [`EBA_RCV_W-1:0]      rcv_cnt_q, rcv_cnt_d;
	logic                       pend_q, pend_d;
	logic                       width_q, width_d;
	logic                       grant_n_q, grant_n_d;
	logic                       oe_q, oe_d;
	logic                       ext_ack_q, ext_ack_d;
	logic                       int_ack_q, int_ack_d;
	logic                       ale_q, ale_d;
	logic                       ale_half_q, ale_half_d;
	logic                       rd_q, rd_d;
	logic                       wr_q, wr_d;
	logic                       dummy_q, dummy_d;
	logic                       stall_q, stall_d;
	logic                       busy_q, busy_d;
	logic                       more_q, more_d;
	logic                       wr_dir_q, wr_dir_d;
	logic [`EBA_BLK_W-1:0]      blk_q, blk_d;
	logic                       req_n_sync;
	logic                       req_seen;
	logic [`EBA_RCV_W-1:0]      rcv_need;

	// Recovery count for the block and direction of the access just completed.
	function automatic logic [`EBA_RCV_W-1:0] rcv_lookup(
		input logic [2*`EBA_BLOCKS-1:0] rsel,
		input logic [2*`EBA_BLOCKS-1:0] wsel,
		input logic [`EBA_BLK_W-1:0]    blk,
		input logic                     wr
	);
		logic [`EBA_RCV_W-1:0] v;
		v = wr ? wsel[blk*2 +: 2] : rsel[blk*2 +: 2];
		if (v > `EBA_RCV_TWO) begin
			v = `EBA_RCV_TWO;
		end
		return v;
	endfunction

	eba_sync u_req_sync (
		.clock_i   (clock_i),
		.srst_i    (srst_i),
		.rst_val_i (1'b1),
		.async_i   (ext_master_request_n_i),
		.sync_o    (req_n_sync)
	);

	assign req_seen = ~req_n_sync;
	assign rcv_need = rcv_lookup(read_recovery_sel_i, write_recovery_sel_i, blk_q, wr_dir_q);

	// Internal accesses never wait for the external bus owner.
	always_comb begin
		int_ack_d = ~srst_i & int_req_i & ~int_ack_q;
	end

	always_comb begin
		state_d    = state_q;
		rcv_cnt_d  = rcv_cnt_q;
		pend_d     = pend_q;
		width_d    = width_q;
		grant_n_d  = grant_n_q;
		oe_d       = oe_q;
		ext_ack_d  = 1'b0;
		ale_d      = 1'b0;
		ale_half_d = 1'b0;
		rd_d       = 1'b0;
		wr_d       = 1'b0;
		dummy_d    = 1'b0;
		stall_d    = 1'b0;
		busy_d     = busy_q;
		more_d     = more_q;
		wr_dir_d   = wr_dir_q;
		blk_d      = blk_q;
		case (state_q)
			EBA_IDLE: begin
				// Bus cycle boundary: a pending request wins over a new access unless more sized pieces follow.
				if (req_seen && !(more_q && busy_q)) begin
					state_d   = EBA_GRANT;
					grant_n_d = 1'b0;
					oe_d      = 1'b0;
					stall_d   = ext_req_i;
				end else if (ext_req_i && !ext_ack_q) begin
					state_d  = EBA_ADDR;
					busy_d   = 1'b1;
					more_d   = ext_more_i;
					wr_dir_d = ext_write_i;
					blk_d    = ext_blk_i;
					width_d  = latch_strobe_width_sel_i;
					ale_d    = mux_mode_i;
					ale_half_d = mux_mode_i & latch_strobe_width_sel_i;
					rcv_cnt_d = `EBA_RCV_W'(0);
				end
			end
			EBA_ADDR: begin
				// Long width holds the address one extra cycle before the strobe.
				if (width_q) begin
					state_d = EBA_STRB;
					ale_d   = 1'b0;
				end else begin
					state_d = EBA_DATA;
					rd_d    = ~wr_dir_q;
					wr_d    = wr_dir_q;
				end
			end
			EBA_STRB: begin
				state_d = EBA_DATA;
				rd_d    = ~wr_dir_q;
				wr_d    = wr_dir_q;
			end
			EBA_DATA: begin
				ext_ack_d = 1'b1;
				pend_d    = pend_q | req_seen;
				if (!more_q) begin
					busy_d = 1'b0;
				end
				if (rcv_need != `EBA_RCV_OFF) begin
					state_d   = EBA_RCV;
					rcv_cnt_d = rcv_need;
					dummy_d   = 1'b1;
				end else begin
					state_d = EBA_IDLE;
				end
			end
			EBA_RCV: begin
				// With two dummy cycles a pending request first launches the waiting cycle here, so the
				// request is honoured after it completes; after one dummy cycle it is granted from idle.
				pend_d = pend_q | req_seen;
				if (rcv_cnt_q == `EBA_RCV_ONE) begin
					state_d = EBA_IDLE;
					// After a single dummy cycle the acknowledge still stands, so the
					// access just finished must not be launched a second time.
					if (ext_req_i && pend_d && !ext_ack_q) begin
						state_d  = EBA_ADDR;
						busy_d   = 1'b1;
						more_d   = ext_more_i;
						wr_dir_d = ext_write_i;
						blk_d    = ext_blk_i;
						width_d  = latch_strobe_width_sel_i;
						ale_d    = mux_mode_i;
						ale_half_d = mux_mode_i & latch_strobe_width_sel_i;
						pend_d   = 1'b0;
					end
				end else begin
					dummy_d = 1'b1;
				end
				rcv_cnt_d = rcv_cnt_q - `EBA_RCV_W'(1);
			end
			EBA_GRANT: begin
				stall_d = ext_req_i;
				pend_d  = 1'b0;
				if (!req_seen) begin
					state_d   = EBA_IDLE;
					grant_n_d = 1'b1;
					oe_d      = 1'b1;
				end
			end
			default: begin
				state_d = EBA_IDLE;
			end
		endcase
		if (srst_i) begin
			state_d   = EBA_IDLE;
			rcv_cnt_d = `EBA_RCV_W'(0);
			pend_d    = 1'b0;
			width_d   = `EBA_ALE_RST;
			grant_n_d = 1'b1;
			oe_d      = 1'b1;
			ext_ack_d = 1'b0;
			ale_d     = 1'b0;
			ale_half_d = 1'b0;
			rd_d      = 1'b0;
			wr_d      = 1'b0;
			dummy_d   = 1'b0;
			stall_d   = 1'b0;
			busy_d    = 1'b0;
			more_d    = 1'b0;
			wr_dir_d  = 1'b0;
			blk_d     = `EBA_BLK_W'(0);
		end
	end

	always_ff @(posedge clock_i) begin
		state_q    <= state_d;
		rcv_cnt_q  <= rcv_cnt_d;
		pend_q     <= pend_d;
		width_q    <= width_d;
		grant_n_q  <= grant_n_d;
		oe_q       <= oe_d;
		ext_ack_q  <= ext_ack_d;
		int_ack_q  <= int_ack_d;
		ale_q      <= ale_d;
		ale_half_q <= ale_half_d;
		rd_q       <= rd_d;
		wr_q       <= wr_d;
		dummy_q    <= dummy_d;
		stall_q    <= stall_d;
		busy_q     <= busy_d;
		more_q     <= more_d;
		wr_dir_q   <= wr_dir_d;
		blk_q      <= blk_d;
	end

	assign ext_ack_o            = ext_ack_q;
	assign int_ack_o            = int_ack_q;
	assign ext_stall_o          = stall_q;
	assign latch_strobe_o       = ale_q;
	assign latch_strobe_half_o  = ale_half_q;
	assign rd_strobe_o          = rd_q;
	assign wr_strobe_o          = wr_q;
	assign bus_oe_o             = oe_q;
	assign dummy_cycle_o        = dummy_q;
	assign ext_master_grant_n_o = grant_n_q;
endmodule
`default_nettype wire

// ==== test/eba_arbiter_sva.sv ====
// Concurrent checks on the arbitration block's top ports.
// Assumes one clock_i domain with the synchronous active-high srst_i.
`timescale 1ns/1ps
`default_nettype none
module eba_arbiter_chk (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic mux_mode_i,
	input wire logic int_req_i,
	input wire logic ext_master_request_n_i,
	input wire logic ext_ack_o,
	input wire logic int_ack_o,
	input wire logic ext_stall_o,
	input wire logic latch_strobe_o,
	input wire logic latch_strobe_half_o,
	input wire logic rd_strobe_o,
	input wire logic wr_strobe_o,
	input wire logic bus_oe_o,
	input wire logic dummy_cycle_o,
	input wire logic ext_master_grant_n_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	sequence data_s;
		(rd_strobe_o || wr_strobe_o) ##1 ext_ack_o;
	endsequence
	AST_STROBE_LONG: assert property (latch_strobe_o && latch_strobe_half_o |-> ##2 data_s)
		else $error("long strobe not followed by the data phase");
	AST_STROBE_SHORT: assert property (latch_strobe_o && !latch_strobe_half_o |-> ##1 data_s)
		else $error("short strobe not followed by the data phase");
	AST_STROBE_MUX: assert property (latch_strobe_o |-> mux_mode_i)
		else $error("strobe outside multiplexed mode");
	AST_GRANT_FLOAT: assert property (ext_master_grant_n_o == bus_oe_o)
		else $error("acknowledge and bus drive disagree");
	AST_GRANT_QUIET: assert property (!ext_master_grant_n_o |->
		!(latch_strobe_o || rd_strobe_o || wr_strobe_o))
		else $error("bus cycle while granted away");
	AST_GRANT_EDGE: assert property ($fell(ext_master_grant_n_o) |->
		!$past(rd_strobe_o) && !$past(wr_strobe_o) && !$past(latch_strobe_o))
		else $error("grant inside a bus cycle");
	AST_ACK_DATA: assert property (ext_ack_o |->
		$past(rd_strobe_o) || $past(wr_strobe_o))
		else $error("cycle end without data strobe");
	AST_DUMMY_QUIET: assert property (dummy_cycle_o |->
		!(rd_strobe_o || wr_strobe_o || latch_strobe_o))
		else $error("strobe during recovery");
	AST_STALL: assert property (ext_stall_o |->
		!ext_master_grant_n_o || !$past(ext_master_grant_n_o))
		else $error("stall without grant");
	AST_RELEASE: assert property ($rose(ext_master_request_n_i) |->
		##[1:6] ext_master_grant_n_o)
		else $error("acknowledge not dropped after release");
	AST_INT_SERVED: assert property (int_req_i && !ext_master_grant_n_o && !int_ack_o |->
		##[1:2] int_ack_o)
		else $error("internal access held up by grant");
	// A request seen in recovery is granted only from idle, after the last dummy cycle,
	// so a grant never follows a dummy cycle directly.
	AST_GRANT_DUMMY: assert property ($fell(ext_master_grant_n_o) |->
		!$past(dummy_cycle_o))
		else $error("grant straight after a dummy cycle");
endmodule
bind eba_arbiter eba_arbiter_chk u_chk (.clock_i(clock_i), .srst_i(srst_i), .mux_mode_i(mux_mode_i),
	.int_req_i(int_req_i), .ext_master_request_n_i(ext_master_request_n_i), .ext_ack_o(ext_ack_o),
	.int_ack_o(int_ack_o), .ext_stall_o(ext_stall_o), .latch_strobe_o(latch_strobe_o),
	.latch_strobe_half_o(latch_strobe_half_o), .rd_strobe_o(rd_strobe_o), .wr_strobe_o(wr_strobe_o),
	.bus_oe_o(bus_oe_o), .dummy_cycle_o(dummy_cycle_o), .ext_master_grant_n_o(ext_master_grant_n_o));
`default_nettype wire

// ==== test/eba_ext_master.sv ====
// Behavioural outside bus master: asks for the bus, keeps it a while, gives it back.
// Assumes the request pin idles high and go_i stays high until done_o.
`timescale 1ns/1ps
`default_nettype none
module eba_ext_master (
	input  wire logic       clock_i,                // System clock.
	input  wire logic       go_i,                   // Start one tenure.
	input  wire logic [3:0] hold_i,                 // Granted cycles to keep, less one.
	input  wire logic       ext_master_grant_n_i,   // Acknowledge, active low.
	output logic            ext_master_request_n_o, // Request, active low.
	output logic            done_o                  // Tenure over.
);
	int cnt;
	initial begin
		ext_master_request_n_o = 1'b1;
		done_o = 1'b0;
		cnt = 0;
	end
	always @(posedge clock_i) begin
		if (!go_i) begin
			done_o <= 1'b0;
			cnt <= 0;
		end else if (ext_master_request_n_o && !done_o) begin
			ext_master_request_n_o <= 1'b0;
		end else if (!ext_master_request_n_o && !ext_master_grant_n_i) begin
			cnt <= cnt + 1;
			if (cnt == int'(hold_i)) begin
				ext_master_request_n_o <= 1'b1;
				done_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench: random shaped accesses, then grants to an outside master.
// Assumes the arbiter, its package and the outside master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock_i, srst_i, mux_mode_i, sel, ext_req_i, ext_write_i, ext_more_i, int_req_i;
	logic [7:0] rsel, wsel;
	logic [1:0] ext_blk_i;
	logic ext_ack_o, int_ack_o, ext_stall_o, latch_strobe_o, latch_strobe_half_o, rd_strobe_o;
	logic wr_strobe_o, bus_oe_o, dummy_cycle_o, grant_n, req_n, go, done, stl, ia;
	logic [31:0] lfsr;
	int n_mismatch, total_checks, n_gnt, i;
	eba_arbiter uut (.clock_i(clock_i), .srst_i(srst_i), .mux_mode_i(mux_mode_i),
		.latch_strobe_width_sel_i(sel), .read_recovery_sel_i(rsel), .write_recovery_sel_i(wsel),
		.ext_req_i(ext_req_i), .ext_blk_i(ext_blk_i), .ext_write_i(ext_write_i),
		.ext_more_i(ext_more_i), .int_req_i(int_req_i), .ext_master_request_n_i(req_n),
		.ext_ack_o(ext_ack_o), .int_ack_o(int_ack_o), .ext_stall_o(ext_stall_o),
		.latch_strobe_o(latch_strobe_o), .latch_strobe_half_o(latch_strobe_half_o),
		.rd_strobe_o(rd_strobe_o), .wr_strobe_o(wr_strobe_o), .bus_oe_o(bus_oe_o),
		.dummy_cycle_o(dummy_cycle_o), .ext_master_grant_n_o(grant_n));
	eba_ext_master u_master (.clock_i(clock_i), .go_i(go), .hold_i(4'h3),
		.ext_master_grant_n_i(grant_n), .ext_master_request_n_o(req_n), .done_o(done));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One external cycle, with the bench's expectations worked out from the settings.
	task automatic access(input logic [1:0] b, input logic w, input logic m);
		int k, ns, nh, nd, nx, ny, rc;
		k = 0; ns = 0; nh = 0; nd = 0; nx = 0; ny = 0;
		stl = 1'b0;
		@(posedge clock_i);
		ext_req_i <= 1'b1; ext_blk_i <= b; ext_write_i <= w; ext_more_i <= m;
		do begin
			@(posedge clock_i); #1;
			k++; ns += latch_strobe_o; nh += latch_strobe_half_o; ny += dummy_cycle_o;
			nd += w ? wr_strobe_o : rd_strobe_o; nx += w ? rd_strobe_o : wr_strobe_o;
			stl |= ext_stall_o; n_gnt += !grant_n;
		end while (ext_ack_o !== 1'b1 && k < 100);
		repeat (3) begin
			@(posedge clock_i); ext_req_i <= 1'b0; #1;
			ny += dummy_cycle_o; n_gnt += !m && !grant_n ? 0 : !grant_n;
		end
		rc = int'(2'((w ? wsel : rsel) >> (2 * b)));
		chk(8'(nd + 4 * nx), 8'h01);
		chk(8'(ny), rc == 3 ? 8'h02 : 8'(rc));
		chk(8'(ns), {7'h00, mux_mode_i});
		chk(8'(nh), {7'h00, mux_mode_i & sel});
		if (!stl) chk(8'(k), sel ? 8'h04 : 8'h03);
	endtask
	initial begin
		{mux_mode_i, ext_req_i, ext_write_i, ext_more_i, int_req_i, go} = '0;
		{sel, srst_i} = 2'h3;
		{rsel, wsel, ext_blk_i} = '0;
		lfsr = 32'h84F70225;
		n_mismatch = 0; total_checks = 0; n_gnt = 0;
		repeat (4) @(posedge clock_i);
		srst_i <= 1'b0;
		for (i = 0; i < 32; i++) begin
			@(posedge clock_i);
			lfsr = lfsr_next(lfsr);
			mux_mode_i <= lfsr[0]; sel <= lfsr[1] | (i < 2); int_req_i <= lfsr[24];
			rsel <= lfsr[15:8]; wsel <= lfsr[23:16];
			access(lfsr[26:25], lfsr[27], 1'b0);
		end
		// Outside master takes the bus; an external access must wait for the release.
		@(posedge clock_i);
		int_req_i <= 1'b1; go <= 1'b1;
		for (i = 0; i < 20 && grant_n !== 1'b0; i++) begin
			@(posedge clock_i); #1;
		end
		chk({6'h00, grant_n, bus_oe_o}, 8'h00);
		ia = int_ack_o;
		@(posedge clock_i); #1;
		chk({7'h00, ia ^ int_ack_o}, 8'h01);
		access(2'h1, 1'b0, 1'b0);
		chk({7'h00, stl}, 8'h01);
		chk({7'h00, done}, 8'h01);
		@(posedge clock_i);
		go <= 1'b0;
		// A sized transfer keeps the bus until its last piece is done.
		@(posedge clock_i); n_gnt = 0; go <= 1'b1;
		access(2'h2, 1'b1, 1'b1);
		access(2'h2, 1'b1, 1'b0);
		chk(8'(n_gnt), 8'h00);
		for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge clock_i);
		chk({7'h00, done}, 8'h01);
		end_of_test();
	end
	initial begin
		#100000;
		n_mismatch++;
		$display("unexpected at %0t: run did not finish", $time);
		end_of_test();
	end
endmodule
`default_nettype wire
